/* src/traction_drive_interlock_logic.sv */
// drive command and safety interlock logic with its apb register file
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module traction_drive_interlock_logic
  import traction_drive_pkg::*;
#(
  parameter int TICK_CYCLES = LOOP_CYCLES,
  parameter int SRC_N       = SRC_COUNT
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [17:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [SRC_N-1:0][7:0] src_level,
  input  wire logic [7:0]            throttle_pct,
  input  wire logic                  key_switch_on,
  input  wire logic                  motor_forward,
  input  wire logic                  motor_stopped,
  output drive_cmd_t                 drive_cmd,
  output fault_status_t              fault_status
);
  logic [15:0]        cfg_r [NUM_CFG];
  logic [NUM_CFG-1:0] hit;
  logic [15:0]        word_idx;
  logic               aligned, stat_hit, any_hit, err_r;
  logic [31:0]        rd_mux, rd_data_r;
  logic [15:0]        status_word;

  logic [23:0]        tick_cnt_r;
  logic               tick_r;
  logic               key_meta_r, key_on_r, key_prev_r;
  logic               ilk_prev_r, ilk_was_on_r, em_in_r;

  logic               fwd_map, rev_map, fwd_raw, rev_raw;
  logic               fwd_now, rev_now, conflict_now, ilk_now;
  logic               thr_active, dir_active, ilk_check, key_rise;
  logic [1:0]         pedal_type, return_type;
  logic               pedal_check, return_check;
  logic               pedal_fault_r, pedal_fault_nxt;
  logic               return_fault_r, return_fault_nxt;
  logic               wiring_r, wiring_nxt, redund_nxt;
  logic               em_open_map, em_open, em_closed_map, em_closed;
  logic               em_in, em_allow, em_timeout;
  logic               em_active_r, em_nxt, em_dir_fwd_r, em_dir_fwd_nxt;
  logic               em_stopped_r, em_stopped_nxt;
  logic               lockout_r, lockout_nxt, em_pedal_r, em_pedal_nxt;
  logic               drive_ok;
  logic [7:0]         brake_lvl, limit_lvl, em_cur_w, em_speed_w;
  logic [15:0]        opt;
  logic [NUM_TIMERS-1:0] timer_run, expired;
  logic [15:0]        timer_lim [NUM_TIMERS];
  drive_cmd_t         cmd_nxt, drive_cmd_r;
  fault_status_t      fault_nxt, fault_status_r;

  // unmapped or out-of-range selections read as the always-off object
  // sources come in as an argument so continuous users re-evaluate on every change
  function automatic logic [7:0] pick(input logic [SRC_N-1:0][7:0] src, input logic [15:0] sel);
    if (sel == ALWAYS_OFF_OBJ || sel >= 16'(SRC_N)) begin
      return 8'h00;
    end
    return src[sel[6:0]];
  endfunction

  // low byte holds the minimum, high byte the maximum set point
  function automatic logic [7:0] interp(input logic [15:0] lims,
                                        input logic [7:0]  lvl);
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  v;
    logic [15:0] span;
    lo = lims[7:0];
    hi = lims[15:8];
    v = (lvl > FULL_SCALE) ? FULL_SCALE : lvl;
    if (hi <= lo) begin
      return lo;
    end
    span = (16'(hi - lo) * 16'(v)) / 16'(FULL_SCALE);
    return 8'(lo + span[7:0]);
  endfunction

  // control-loop tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 24'h00_0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 24'h00_0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 24'h00_0001;
      tick_r <= 1'b0;
    end
  end

  // key switch is a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_meta_r <= 1'b0;
      key_on_r <= 1'b0;
    end else begin
      key_meta_r <= key_switch_on;
      key_on_r <= key_meta_r;
    end
  end

  assign opt         = cfg_r[S_OPTIONS];
  assign pedal_type  = cfg_r[S_PEDAL_TYPE][1:0];
  assign return_type = cfg_r[S_RETURN_TYPE][1:0];
  assign brake_lvl   = pick(src_level, cfg_r[S_BRAKE_SEL]);
  assign limit_lvl   = pick(src_level, cfg_r[S_SPEED_LIMIT_SEL]);
  assign em_cur_w    = cfg_r[S_EMERG_CURRENT][7:0];
  assign em_speed_w  = cfg_r[S_EMERG_SPEED][7:0];

  // direction inputs
  assign fwd_map      = cfg_r[S_FORWARD_SEL] != ALWAYS_OFF_OBJ;
  assign rev_map      = cfg_r[S_REVERSE_SEL] != ALWAYS_OFF_OBJ;
  assign fwd_raw      = pick(src_level, cfg_r[S_FORWARD_SEL]) != 8'h00;
  assign rev_raw      = pick(src_level, cfg_r[S_REVERSE_SEL]) != 8'h00;
  assign fwd_now      = fwd_map ? fwd_raw : (rev_map && !rev_raw);
  assign rev_now      = rev_map ? rev_raw : (fwd_map && !fwd_raw);
  assign conflict_now = fwd_map && rev_map && fwd_raw && rev_raw;
  assign ilk_now      = pick(src_level, cfg_r[S_INTERLOCK_SEL]) != 8'h00;
  assign thr_active   = {8'h00, throttle_pct} >= cfg_r[S_PEDAL_THRESHOLD];
  assign dir_active   = fwd_now || rev_now;

  // start checks; a quick interlock bounce is not a fresh start
  assign key_rise     = key_on_r && !key_prev_r;
  assign ilk_check    = ilk_now && !ilk_prev_r && !(ilk_was_on_r && !expired[T_GRACE]);
  assign pedal_check  = (pedal_type == CHECK_ON_ILK && ilk_check) ||
                        (pedal_type == CHECK_ON_KEY && key_rise);
  assign return_check = (return_type == CHECK_ON_ILK && ilk_check) ||
                        (return_type == CHECK_ON_KEY && key_rise);
  assign pedal_fault_nxt  = thr_active && (pedal_check ||
                            (pedal_fault_r && pedal_type != CHECK_OFF));
  assign return_fault_nxt = dir_active && (return_check ||
                            (return_fault_r && return_type != CHECK_OFF));
  // set wins over the key-off clear
  assign wiring_nxt = (wiring_r && key_on_r) || (cfg_r[S_PEDAL_LATCH] != 16'h0000 &&
                      pedal_fault_r && expired[T_LATCH]);

  // emergency reverse
  assign em_open_map   = cfg_r[S_EMERG_OPEN_SEL] != ALWAYS_OFF_OBJ;
  assign em_open       = pick(src_level, cfg_r[S_EMERG_OPEN_SEL]) != 8'h00;
  assign em_closed_map = cfg_r[S_EMERG_CLOSED_SEL] != ALWAYS_OFF_OBJ;
  assign em_closed     = pick(src_level, cfg_r[S_EMERG_CLOSED_SEL]) != 8'h00;
  assign em_in         = em_open_map && em_open && !em_closed;
  assign redund_nxt    = em_closed_map && (em_closed == em_open);
  assign em_allow      = !opt[OPT_FWD_ONLY_BIT] || motor_forward;
  assign em_timeout    = expired[T_EMERG];
  // once engaged the motor turns round, so travel direction no longer gates it
  assign em_nxt = em_in && !em_timeout && !redund_nxt && (em_active_r || em_allow);
  assign em_dir_fwd_nxt = em_active_r ? em_dir_fwd_r : !motor_forward;
  assign em_stopped_nxt = em_nxt && (em_stopped_r || motor_stopped);
  assign lockout_nxt = (em_nxt && opt[OPT_DIR_LOCK_BIT]) ||
                       (lockout_r && (ilk_now || thr_active || dir_active));
  assign em_pedal_nxt = opt[OPT_ANTI_TIEDOWN_BIT] && em_in && ilk_now &&
                        (em_pedal_r || (!em_in_r && ilk_prev_r));

  assign timer_run[T_GRACE]  = !ilk_prev_r;
  assign timer_run[T_EMERG]  = em_in_r;
  assign timer_run[T_LATCH]  = pedal_fault_r;
  assign timer_lim[T_GRACE]  = cfg_r[S_ILK_GRACE];
  assign timer_lim[T_EMERG]  = cfg_r[S_EMERG_TIME];
  assign timer_lim[T_LATCH]  = cfg_r[S_PEDAL_LATCH];

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    elapsed_timer #(.CNT_W(24)) u_timer (
      .pclk         (pclk),
      .presetn      (presetn),
      .tick         (tick_r),
      .run          (timer_run[t]),
      .limit_tenths (timer_lim[t]),
      .expired      (expired[t])
    );
  end

  assign drive_ok = ilk_now && key_on_r && !conflict_now && !pedal_fault_nxt &&
                    !return_fault_nxt && !wiring_nxt && !redund_nxt && !em_pedal_nxt;

  always_comb begin
    cmd_nxt = '0;
    cmd_nxt.contactor_en = ilk_now;
    cmd_nxt.emerg_active = em_nxt;
    cmd_nxt.brake_active = brake_lvl != 8'h00;
    cmd_nxt.brake_decel_pct = interp(cfg_r[S_BRAKE_DECEL], brake_lvl);
    if (em_nxt) begin
      cmd_nxt.drive_en = drive_ok;
      cmd_nxt.dir_fwd = em_dir_fwd_nxt;
      cmd_nxt.dir_rev = !em_dir_fwd_nxt;
      cmd_nxt.speed_pct = em_speed_w;
      cmd_nxt.current_pct = em_cur_w;
      cmd_nxt.ramp_accel = em_stopped_nxt;
      cmd_nxt.ramp_time = em_stopped_nxt ? cfg_r[S_EMERG_ACCEL] : cfg_r[S_EMERG_DECEL];
    end else begin
      cmd_nxt.drive_en = drive_ok && !lockout_nxt && dir_active;
      cmd_nxt.dir_fwd = fwd_now && !conflict_now;
      cmd_nxt.dir_rev = rev_now && !conflict_now;
      cmd_nxt.speed_pct = interp(pick(src_level, cfg_r[S_SPEED_MODE_SEL]) == 8'h00 ?
                          cfg_r[S_MODE1_SPEED] : cfg_r[S_MODE2_SPEED], limit_lvl);
      cmd_nxt.current_pct = FULL_SCALE;
    end
  end

  always_comb begin
    fault_nxt = '0;
    fault_nxt.high_pedal = pedal_fault_nxt;
    fault_nxt.static_return = return_fault_nxt;
    fault_nxt.wiring = wiring_nxt;
    fault_nxt.redundancy = redund_nxt;
    fault_nxt.emerg_pedal = em_pedal_nxt;
    fault_nxt.dir_conflict = conflict_now;
    fault_nxt.emerg_lockout = lockout_nxt;
    fault_nxt.emerg_timeout = em_timeout;
  end

  // history sampled once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_prev_r <= 1'b0;
      ilk_prev_r <= 1'b0;
      ilk_was_on_r <= 1'b0;
      em_in_r <= 1'b0;
    end else if (tick_r) begin
      key_prev_r <= key_on_r;
      ilk_prev_r <= ilk_now;
      ilk_was_on_r <= key_on_r && (ilk_was_on_r || ilk_now);
      em_in_r <= em_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pedal_fault_r <= 1'b0;
      return_fault_r <= 1'b0;
      wiring_r <= 1'b0;
      fault_status_r <= '0;
    end else if (tick_r) begin
      pedal_fault_r <= pedal_fault_nxt;
      return_fault_r <= return_fault_nxt;
      wiring_r <= wiring_nxt;
      fault_status_r <= fault_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      em_active_r <= 1'b0;
      em_dir_fwd_r <= 1'b0;
      em_stopped_r <= 1'b0;
      lockout_r <= 1'b0;
      em_pedal_r <= 1'b0;
    end else if (tick_r) begin
      em_active_r <= em_nxt;
      em_dir_fwd_r <= em_dir_fwd_nxt;
      em_stopped_r <= em_stopped_nxt;
      lockout_r <= lockout_nxt;
      em_pedal_r <= em_pedal_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_cmd_r <= '0;
    end else if (tick_r) begin
      drive_cmd_r <= cmd_nxt;
    end
  end

  assign drive_cmd = drive_cmd_r;
  assign fault_status = fault_status_r;

  // apb slave: read data and error are captured in the setup cycle
  assign word_idx = paddr[17:2];
  assign aligned = paddr[1:0] == 2'h0;
  for (genvar k = 0; k < NUM_CFG; k++) begin : g_hit
    assign hit[k] = aligned && word_idx == CFG_INDEX[k];
  end
  assign stat_hit = aligned && word_idx == IDX_STATUS;
  assign any_hit = (|hit) || stat_hit;
  assign status_word = {3'h0, drive_cmd_r.contactor_en, drive_cmd_r.drive_en,
                        drive_cmd_r.dir_fwd, drive_cmd_r.dir_rev,
                        drive_cmd_r.emerg_active, fault_status_r};

  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int k = 0; k < NUM_CFG; k++) begin
      if (hit[k]) begin
        rd_mux = {16'h0000, cfg_r[k]};
      end
    end
    if (stat_hit) begin
      rd_mux = {16'h0000, status_word};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (psel && !penable) begin
      rd_data_r <= pwrite ? 32'h0000_0000 : rd_mux;
      err_r <= !any_hit || (pwrite && stat_hit);
    end
  end

  // zero wait states keeps the slave simple; pready rides on penable
  assign pready = psel && penable;
  assign pslverr = psel && penable && err_r;
  assign prdata = rd_data_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NUM_CFG; k++) begin
        cfg_r[k] <= CFG_RESET[k];
      end
    end else if (psel && penable && pwrite && !err_r) begin
      for (int k = 0; k < NUM_CFG; k++) begin
        if (hit[k] && pstrb[0]) begin
          cfg_r[k][7:0] <= pwdata[7:0];
        end
        if (hit[k] && pstrb[1]) begin
          cfg_r[k][15:8] <= pwdata[15:8];
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_contactor;
    tick_r |=> drive_cmd_r.contactor_en == $past(ilk_now);
  endproperty
  a_contactor: assert property (p_contactor) else $error("contactor not tied to interlock");

  property p_conflict;
    tick_r && conflict_now |=> !drive_cmd_r.drive_en && fault_status_r.dir_conflict;
  endproperty
  a_conflict: assert property (p_conflict) else $error("drive enabled on direction conflict");

  property p_forward;
    tick_r && fwd_now && !conflict_now && !em_nxt |=> drive_cmd_r.dir_fwd && !drive_cmd_r.dir_rev;
  endproperty
  a_forward: assert property (p_forward) else $error("forward request not commanded");

  property p_infer;
    tick_r && fwd_map && !rev_map && !em_nxt |=> drive_cmd_r.dir_rev != drive_cmd_r.dir_fwd;
  endproperty
  a_infer: assert property (p_infer) else $error("unmapped direction not inverted");

  property p_em_off;
    tick_r && !em_open_map |=> !em_active_r ##1 !em_active_r;
  endproperty
  a_em_off: assert property (p_em_off) else $error("emergency active with open input off");

  property p_redund;
    tick_r && redund_nxt |=> fault_status_r.redundancy && !drive_cmd_r.emerg_active;
  endproperty
  a_redund: assert property (p_redund) else $error("redundancy mismatch not flagged");

  property p_fwd_only;
    tick_r && !em_active_r && opt[OPT_FWD_ONLY_BIT] && !motor_forward |=> !em_active_r;
  endproperty
  a_fwd_only: assert property (p_fwd_only) else $error("emergency started while not forward");

  property p_em_limits;
    tick_r && em_nxt |=> drive_cmd_r.current_pct == $past(em_cur_w) &&
                         drive_cmd_r.speed_pct == $past(em_speed_w);
  endproperty
  a_em_limits: assert property (p_em_limits) else $error("emergency limits not applied");

  property p_pedal;
    tick_r && pedal_check && thr_active |=> fault_status_r.high_pedal && !drive_cmd_r.drive_en;
  endproperty
  a_pedal: assert property (p_pedal) else $error("pedal start fault missed");

  property p_wiring_hold;
    wiring_r && key_on_r |=> wiring_r;
  endproperty
  a_wiring_hold: assert property (p_wiring_hold) else $error("wiring fault cleared early");

  c_emerg: cover property (tick_r && em_nxt && !em_active_r);
  c_pedal: cover property (tick_r && pedal_fault_nxt && !pedal_fault_r);
  c_wiring: cover property (tick_r && wiring_nxt && !wiring_r);
endmodule

/* src/traction_drive_pkg.sv */
// register map, reset values, timing and command types of the drive interlock
package traction_drive_pkg;

  localparam int CLK_MHZ         = 125;
  localparam int LOOP_PERIOD_US  = 1000;
  localparam int LOOP_CYCLES     = LOOP_PERIOD_US * CLK_MHZ;
  localparam int TENTH_S_US      = 100000;
  localparam int TICKS_PER_TENTH = TENTH_S_US / LOOP_PERIOD_US;
  localparam int SRC_COUNT       = 121;

  localparam int NUM_TIMERS = 3;
  localparam int T_GRACE    = 0;
  localparam int T_EMERG    = 1;
  localparam int T_LATCH    = 2;

  localparam logic [15:0] ALWAYS_OFF_OBJ = 16'h0000;
  localparam logic [7:0]  FULL_SCALE     = 8'h64;
  localparam logic [1:0]  CHECK_OFF      = 2'h0;
  localparam logic [1:0]  CHECK_ON_ILK   = 2'h1;
  localparam logic [1:0]  CHECK_ON_KEY   = 2'h2;

  localparam int OPT_DIR_LOCK_BIT     = 0;
  localparam int OPT_FWD_ONLY_BIT     = 1;
  localparam int OPT_ANTI_TIEDOWN_BIT = 6;

  typedef enum logic [4:0] {
    S_SPEED_LIMIT_SEL, S_INTERLOCK_SEL, S_EMERG_CURRENT, S_EMERG_SPEED,
    S_EMERG_ACCEL, S_EMERG_DECEL, S_EMERG_TIME, S_FORWARD_SEL, S_REVERSE_SEL,
    S_EMERG_OPEN_SEL, S_SPEED_MODE_SEL, S_BRAKE_SEL, S_EMERG_CLOSED_SEL,
    S_OPTIONS, S_PEDAL_TYPE, S_RETURN_TYPE, S_PEDAL_THRESHOLD, S_PEDAL_LATCH,
    S_ILK_GRACE, S_MODE1_SPEED, S_MODE2_SPEED, S_BRAKE_DECEL
  } cfg_slot_t;
  localparam int NUM_CFG = 22;

  // word indices; byte address is four times the index
  localparam logic [15:0] IDX_SPEED_LIMIT_SEL  = 16'h3003;
  localparam logic [15:0] IDX_INTERLOCK_SEL    = 16'h3034;
  localparam logic [15:0] IDX_EMERG_CURRENT    = 16'h3037;
  localparam logic [15:0] IDX_EMERG_SPEED      = 16'h3038;
  localparam logic [15:0] IDX_EMERG_ACCEL      = 16'h3039;
  localparam logic [15:0] IDX_EMERG_DECEL      = 16'h303a;
  localparam logic [15:0] IDX_EMERG_TIME       = 16'h303b;
  localparam logic [15:0] IDX_FORWARD_SEL      = 16'h3041;
  localparam logic [15:0] IDX_REVERSE_SEL      = 16'h3049;
  localparam logic [15:0] IDX_EMERG_OPEN_SEL   = 16'h304a;
  localparam logic [15:0] IDX_SPEED_MODE_SEL   = 16'h304e;
  localparam logic [15:0] IDX_BRAKE_SEL        = 16'h3058;
  localparam logic [15:0] IDX_EMERG_CLOSED_SEL = 16'h305a;
  localparam logic [15:0] IDX_OPTIONS          = 16'h306a;
  localparam logic [15:0] IDX_PEDAL_TYPE       = 16'h3031;
  localparam logic [15:0] IDX_RETURN_TYPE      = 16'h3032;
  localparam logic [15:0] IDX_PEDAL_THRESHOLD  = 16'h3200;
  localparam logic [15:0] IDX_PEDAL_LATCH      = 16'h30dc;
  localparam logic [15:0] IDX_ILK_GRACE        = 16'h3143;
  localparam logic [15:0] IDX_MODE1_SPEED      = 16'h3201;
  localparam logic [15:0] IDX_MODE2_SPEED      = 16'h3202;
  localparam logic [15:0] IDX_BRAKE_DECEL      = 16'h3203;
  localparam logic [15:0] IDX_STATUS           = 16'h3204;

  localparam logic [15:0] CFG_INDEX [NUM_CFG] = '{
    IDX_SPEED_LIMIT_SEL, IDX_INTERLOCK_SEL, IDX_EMERG_CURRENT, IDX_EMERG_SPEED,
    IDX_EMERG_ACCEL, IDX_EMERG_DECEL, IDX_EMERG_TIME, IDX_FORWARD_SEL,
    IDX_REVERSE_SEL, IDX_EMERG_OPEN_SEL, IDX_SPEED_MODE_SEL, IDX_BRAKE_SEL,
    IDX_EMERG_CLOSED_SEL, IDX_OPTIONS, IDX_PEDAL_TYPE, IDX_RETURN_TYPE,
    IDX_PEDAL_THRESHOLD, IDX_PEDAL_LATCH, IDX_ILK_GRACE, IDX_MODE1_SPEED,
    IDX_MODE2_SPEED, IDX_BRAKE_DECEL};

  // times are in tenths of a second, speeds and currents in percent
  localparam logic [15:0] CFG_RESET [NUM_CFG] = '{
    16'h0064, 16'h0003, 16'h0064, 16'h000f, 16'h000a, 16'h000a, 16'h0005,
    16'h0070, 16'h0071, 16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0041,
    16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h6400, 16'h6400,
    16'h6400};

  typedef struct packed {
    logic        contactor_en;
    logic        drive_en;
    logic        dir_fwd;
    logic        dir_rev;
    logic        emerg_active;
    logic        brake_active;
    logic        ramp_accel;
    logic [7:0]  speed_pct;
    logic [7:0]  current_pct;
    logic [7:0]  brake_decel_pct;
    logic [15:0] ramp_time;
  } drive_cmd_t;

  typedef struct packed {
    logic high_pedal;
    logic static_return;
    logic wiring;
    logic redundancy;
    logic emerg_pedal;
    logic dir_conflict;
    logic emerg_lockout;
    logic emerg_timeout;
  } fault_status_t;

endpackage

/* src/elapsed_timer.sv */
// loop-tick timer that flags when a running interval passes a limit in tenths
`timescale 1ns/100ps
module elapsed_timer
  import traction_drive_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [15:0] limit_tenths,
  output logic             expired
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] limit_ticks;

  assign limit_ticks = CNT_W'(limit_tenths) * CNT_W'(TICKS_PER_TENTH);

  // saturates so a held condition never wraps back under the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (!run) begin
      count_r <= '0;
    end else if (tick && count_r != '1) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign expired = run && (count_r >= limit_ticks);
endmodule

/* verif/vehicle_switch_model.sv */
// operator switch and interlock sources as mapped normalized objects
`timescale 1ns/100ps
module vehicle_switch_model
  import traction_drive_pkg::*;
(
  input  wire logic                      fwd,
  input  wire logic                      rev,
  input  wire logic                      ilk,
  input  wire logic [1:0]                emergency_reverse,
  output logic      [SRC_COUNT-1:0][7:0] src_level
);
  // unused objects read as zero, object 100 is the always-on source
  always_comb begin
    src_level      = '0;
    src_level[100] = FULL_SCALE;
    src_level[112] = fwd ? FULL_SCALE : 8'h00;
    src_level[113] = rev ? FULL_SCALE : 8'h00;
    src_level[3]   = ilk ? FULL_SCALE : 8'h00;
    src_level[5]   = emergency_reverse[0] ? FULL_SCALE : 8'h00;
    src_level[6]   = emergency_reverse[1] ? FULL_SCALE : 8'h00;
  end
endmodule

/* verif/traction_drive_interlock_logic_tb_top.sv */
// self-checking bench for the drive interlock logic
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected %0t got %h exp %h", $time, a, b); end end
module traction_drive_interlock_logic_tb_top;
  import traction_drive_pkg::*;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                      key, fwd, rev, ilk, mfwd, mstop;
  logic [7:0]                thr;
  logic [1:0]                emergency_reverse;
  logic [17:0]               paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [SRC_COUNT-1:0][7:0] lvl;
  drive_cmd_t                cmd;
  fault_status_t             flt;
  int                        miscompares, n_tests, sel;

  vehicle_switch_model vehicle_switch_model_i (.fwd(fwd), .rev(rev), .ilk(ilk), .emergency_reverse(emergency_reverse),
    .src_level(lvl));
  // small tick keeps the run short
  traction_drive_interlock_logic #(.TICK_CYCLES(8)) traction_drive_interlock_logic_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_level(lvl), .throttle_pct(thr), .key_switch_on(key),
    .motor_forward(mfwd), .motor_stopped(mstop), .drive_cmd(cmd), .fault_status(flt));

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // five control ticks let the result settle
  task automatic settle();
    repeat (40) @(posedge pclk);
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    sel = $urandom(32'h7628208a);
    {presetn, psel, penable, pwrite, key, fwd, rev, ilk} = '0;
    {emergency_reverse, paddr, pwdata, thr, mstop} = '0;
    mfwd = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NUM_CFG; i++) begin
      apb(1'b0, CFG_INDEX[i], 32'h0000_0000);
      `CHK(rd, {16'h0000, CFG_RESET[i]})
    end
    apb(1'b0, 16'h3100, 32'h0000_0000);
    `CHK(err, 1'b1)
    sel = $urandom_range(120, 1);
    apb(1'b1, IDX_SPEED_LIMIT_SEL, sel);
    apb(1'b0, IDX_SPEED_LIMIT_SEL, 32'h0000_0000);
    `CHK(rd, sel)
    key <= 1'b1;
    ilk <= 1'b1;
    fwd <= 1'b1;
    settle();
    `CHK(cmd.contactor_en, 1'b1)
    `CHK(cmd.speed_pct, (sel == 3 || sel == 100 || sel == 112) ? CFG_RESET[S_MODE1_SPEED][15:8] : CFG_RESET[S_MODE1_SPEED][7:0])
    `CHK({cmd.drive_en, cmd.dir_fwd}, 2'b11)
    rev <= 1'b1;
    settle();
    `CHK(cmd.drive_en, 1'b0)
    // forward unmapped: reverse alone decides direction
    apb(1'b1, IDX_FORWARD_SEL, 32'h0000_0000);
    settle();
    `CHK({cmd.dir_fwd, cmd.dir_rev}, 2'b01)
    rev <= 1'b0;
    settle();
    `CHK({cmd.dir_fwd, cmd.dir_rev}, 2'b10)
    apb(1'b1, IDX_EMERG_OPEN_SEL, 32'h0000_0005);
    apb(1'b1, IDX_EMERG_CLOSED_SEL, 32'h0000_0006);
    emergency_reverse <= 2'b01;
    settle();
    `CHK(flt.emerg_pedal, 1'b1)
    emergency_reverse <= 2'b11;
    settle();
    `CHK(flt.redundancy, 1'b1)
    emergency_reverse <= 2'b00;
    ilk <= 1'b0;
    settle();
    `CHK(cmd.contactor_en, 1'b0)
    // zero grace makes every interlock return a fresh start
    apb(1'b1, IDX_EMERG_CLOSED_SEL, 32'h0000_0000);
    apb(1'b1, IDX_ILK_GRACE, 32'h0000_0000);
    thr <= 8'($urandom_range(100, 1));
    ilk <= 1'b1;
    settle();
    `CHK(flt.high_pedal, 1'b1)
    thr <= 8'h00;
    settle();
    `CHK(flt.high_pedal, 1'b0)
    apb(1'b1, IDX_OPTIONS, {16'h0000, CFG_RESET[S_OPTIONS] | 16'(1 << OPT_FWD_ONLY_BIT)});
    apb(1'b1, IDX_BRAKE_SEL, 32'h0000_0064);
    mfwd <= 1'b0;
    emergency_reverse <= 2'b01;
    settle();
    `CHK(cmd.emerg_active, 1'b0)
    `CHK({cmd.brake_active, cmd.brake_decel_pct}, {1'b1, CFG_RESET[S_BRAKE_DECEL][15:8]})
    mfwd <= 1'b1;
    settle();
    `CHK({cmd.emerg_active, cmd.dir_fwd, cmd.dir_rev}, 3'b101)
    `CHK(cmd.current_pct, CFG_RESET[S_EMERG_CURRENT][7:0])
    `CHK(cmd.speed_pct, CFG_RESET[S_EMERG_SPEED][7:0])
    mstop <= 1'b1;
    settle();
    `CHK({cmd.ramp_accel, cmd.ramp_time}, {1'b1, CFG_RESET[S_EMERG_ACCEL]})
    apb(1'b1, IDX_EMERG_TIME, 32'h0000_0000);
    settle();
    `CHK({cmd.emerg_active, flt.emerg_timeout, flt.emerg_lockout}, 3'b011)
    end_of_test();
  end
endmodule
